// ==== hdl/qpw_bank.v ====
/*
 Register bank for ingress queue policing and packet-memory early drop, with
 the live settings fed to the policer for one frame decision port at a time.
 Assumes a simple synchronous register port from the management interface:
 one-cycle write strobes, combinational read data, all in the sys_clk domain.
*/
`timescale 1ns/1ns
`include "qpw_regs.vh"

module qpw_bank (
	input  wire        sys_clk,             // Core clock, 20 MHz.
	input  wire        reset_n,             // Asynchronous reset, active low.
	input  wire        clk_en,              // All state holds while low.
	input  wire [11:0] reg_addr,            // Register byte offset within the port.
	input  wire        reg_wr,              // Write strobe.
	input  wire        reg_rd,              // Read strobe, a monitor read.
	input  wire [31:0] reg_wdata,           // Write data.
	output reg  [31:0] reg_rdata,           // Read data.
	input  wire [10:0] avg_queue_size,      // Average packet-memory occupancy.
	input  wire [23:0] dropped_count,       // Dropped-frame count of the pointed queue.
	input  wire [23:0] green_count,         // Green count of the pointed queue.
	input  wire [23:0] yellow_count,        // Yellow count of the pointed queue.
	input  wire [23:0] red_count,           // Red count of the pointed queue.
	input  wire [2:0]  frame_port,          // Port of the frame being policed.
	input  wire [1:0]  frame_queue,         // Queue of the frame being policed.
	input  wire        frame_is_ip,         // Frame carries an IP header.
	input  wire        frame_is_srp,        // Frame is a stream reservation frame.
	input  wire [1:0]  dscp_color,          // Color taken from the DSCP field.
	input  wire [1:0]  remap_color,         // Color after DSCP remapping.
	input  wire        red_drop_request,    // Early-drop logic wants to drop.
	input  wire        frame_valid,         // Frame decision this cycle.
	output reg         police_active,       // Policing and early drop applied.
	output reg         color_blind,         // Police without input color.
	output reg  [1:0]  input_color,         // Color presented to the policer.
	output reg         mark_enable,         // Write the result color to DSCP.
	output reg  [15:0] committed_rate,      // Committed rate for this frame.
	output reg  [15:0] peak_rate,           // Peak rate for this frame.
	output reg  [15:0] committed_burst,     // Committed burst in bytes.
	output reg  [15:0] peak_burst,          // Peak burst in bytes.
	output reg  [10:0] max_threshold,       // Packet-memory maximum threshold.
	output reg  [10:0] min_threshold,       // Packet-memory minimum threshold.
	output reg  [10:0] memory_drop_scale,   // Drop probability multiplier.
	output reg         drop_all_above_max,  // Drop everything above maximum.
	output reg         frame_drop,          // Frame is dropped by early drop.
	output reg         count_dropped_only,  // Color counters count drops only.
	output reg  [1:0]  monitor_select       // Count chosen for monitor reads.
);

	reg  [31:0] control;
	reg  [31:0] pointer;
	reg  [31:0] thresholds;
	reg  [10:0] drop_scale;
	wire [31:0] sel_rate;
	wire [31:0] sel_burst;
	wire [31:0] frm_rate;
	wire [31:0] frm_burst;
	wire [4:0]  host_slot;
	wire [4:0]  frm_slot;
	wire        wr_rate;
	wire        wr_burst;
	reg  [23:0] early_drop_monitor_count;
	reg  [1:0]  next_input_color;
	reg         next_drop;

	// Slot index from a port and queue pair.
	function [4:0] slot_of;
		input [2:0] port;
		input [1:0] queue;
		begin
			slot_of = {port, 2'h0} + {3'h0, queue};
		end
	endfunction

	// Clamp ports beyond the seventh onto the last slot row.
	function [2:0] port_clamp;
		input [2:0] port;
		begin
			port_clamp = (port > 3'h6) ? 3'h6 : port;
		end
	endfunction

	assign host_slot = slot_of(port_clamp(pointer[18:16]), pointer[1:0]);
	assign frm_slot  = slot_of(control[`QPW_BIT_PORT_BASED] ? port_clamp(frame_port) : 3'h0,
		frame_queue);
	assign wr_rate   = reg_wr && (reg_addr == `QPW_OFF_RATE);
	assign wr_burst  = reg_wr && (reg_addr == `QPW_OFF_BURST);

	// Host accesses one slot; the frame path reads another through a second copy.
	qpw_slot_table u_host_table (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.wr_slot  (host_slot),
		.wr_rate  (wr_rate),
		.wr_burst (wr_burst),
		.wr_data  (reg_wdata),
		.rd_slot  (host_slot),
		.rd_rate  (sel_rate),
		.rd_burst (sel_burst)
	);

	qpw_slot_table u_frame_table (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.wr_slot  (host_slot),
		.wr_rate  (wr_rate),
		.wr_burst (wr_burst),
		.wr_data  (reg_wdata),
		.rd_slot  (frm_slot),
		.rd_rate  (frm_rate),
		.rd_burst (frm_burst)
	);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			control    <= `QPW_CONTROL_RESET;
			pointer    <= 32'h00000000;
			thresholds <= `QPW_THRESH_RESET;
			drop_scale <= `QPW_PROB_RESET;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`QPW_OFF_CONTROL: control    <= reg_wdata & `QPW_CONTROL_MASK;
				`QPW_OFF_POINTER: pointer    <= reg_wdata & `QPW_POINTER_MASK;
				`QPW_OFF_THRESH:  thresholds <= reg_wdata & `QPW_THRESH_MASK;
				`QPW_OFF_PROB:    drop_scale <= reg_wdata[26:16];
				default:          control    <= control;
			endcase
		end
	end

	always @* begin
		case (control[9:8])
			`QPW_MON_RED:    early_drop_monitor_count = red_count;
			`QPW_MON_YELLOW: early_drop_monitor_count = yellow_count;
			`QPW_MON_GREEN:  early_drop_monitor_count = green_count;
			default:         early_drop_monitor_count = dropped_count;
		endcase
	end

	always @* begin
		case (reg_addr)
			`QPW_OFF_CONTROL: reg_rdata = control;
			`QPW_OFF_POINTER: reg_rdata = pointer;
			`QPW_OFF_RATE:    reg_rdata = sel_rate;
			`QPW_OFF_BURST:   reg_rdata = sel_burst;
			`QPW_OFF_THRESH:  reg_rdata = thresholds;
			`QPW_OFF_PROB:    reg_rdata = {5'h00, drop_scale, 5'h00, avg_queue_size};
			default:          reg_rdata = 32'h00000000;
		endcase
		if (reg_rd && reg_addr == `QPW_OFF_MONITOR)
			reg_rdata = {8'h00, early_drop_monitor_count};
	end

	always @* begin
		if (!frame_is_ip)
			next_input_color = control[6:5];
		else if (control[`QPW_BIT_REMAP])
			next_input_color = remap_color;
		else
			next_input_color = dscp_color;
	end

	always @* begin
		next_drop = 1'b0;
		if (control[`QPW_BIT_ENABLE] && frame_valid) begin
			if (control[`QPW_BIT_DROP_ALL] && avg_queue_size > thresholds[26:16])
				next_drop = 1'b1;
			else
				next_drop = red_drop_request;
			if (frame_is_srp && !control[`QPW_BIT_DROP_SRP])
				next_drop = 1'b0;
		end
	end

	// Frame-path settings are registered so data outputs come from flip-flops.
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			police_active      <= 1'b0;
			color_blind        <= 1'b0;
			input_color        <= 2'h0;
			mark_enable        <= 1'b0;
			committed_rate     <= 16'h0000;
			peak_rate          <= 16'h0000;
			committed_burst    <= 16'h0000;
			peak_burst         <= 16'h0000;
			max_threshold      <= 11'h000;
			min_threshold      <= 11'h000;
			memory_drop_scale  <= 11'h000;
			drop_all_above_max <= 1'b0;
			frame_drop         <= 1'b0;
			count_dropped_only <= 1'b0;
			monitor_select     <= 2'h0;
		end else if (clk_en) begin
			police_active      <= control[`QPW_BIT_ENABLE];
			color_blind        <= control[`QPW_BIT_MODE];
			input_color        <= control[`QPW_BIT_MODE] ? 2'h0 : next_input_color;
			mark_enable        <= control[`QPW_BIT_ENABLE] & control[`QPW_BIT_MARK];
			committed_rate     <= frm_rate[31:16];
			peak_rate          <= frm_rate[15:0];
			committed_burst    <= frm_burst[31:16];
			peak_burst         <= frm_burst[15:0];
			max_threshold      <= thresholds[26:16];
			min_threshold      <= thresholds[10:0];
			memory_drop_scale  <= drop_scale;
			drop_all_above_max <= control[`QPW_BIT_DROP_ALL];
			frame_drop         <= next_drop;
			count_dropped_only <= control[`QPW_BIT_DROPPED_CLR];
			monitor_select     <= control[9:8];
		end
	end

endmodule

// ==== hdl/qpw_regs.vh ====
/*
 Offsets, field positions, reset values and table sizes of the queue policing
 and early-drop register bank. Assumes inclusion by bare name from hdl/.
*/
`ifndef QPW_REGS_VH
`define QPW_REGS_VH

`define QPW_OFF_CONTROL      12'h80c
`define QPW_OFF_POINTER      12'h804
`define QPW_OFF_RATE         12'h820
`define QPW_OFF_BURST        12'h824
`define QPW_OFF_THRESH       12'h830
`define QPW_OFF_PROB         12'h834
`define QPW_OFF_MONITOR      12'h848

`define QPW_BIT_ENABLE       0
`define QPW_BIT_MODE         1
`define QPW_BIT_DROP_SRP     2
`define QPW_BIT_REMAP        3
`define QPW_BIT_MARK         4
`define QPW_NONIP_LSB        5
`define QPW_BIT_PORT_BASED   7
`define QPW_MONSEL_LSB       8
`define QPW_BIT_DROP_ALL     10
`define QPW_BIT_DROPPED_CLR  11
`define QPW_CONTROL_MASK     32'h00000fff
`define QPW_CONTROL_RESET    32'h00000020

`define QPW_QUEUE_MASK       32'h00000003
`define QPW_PORT_LSB         16
`define QPW_POINTER_MASK     32'h00070003
`define QPW_NUM_PORTS        7
`define QPW_NUM_QUEUES       4
`define QPW_NUM_SLOTS        28

`define QPW_RATE_RESET       32'h10002000
`define QPW_BURST_RESET      32'h10003000
`define QPW_THRESH_RESET     32'h04000080
`define QPW_THRESH_MASK      32'h07ff07ff
`define QPW_PROB_RESET       11'h020
`define QPW_FIELD11_MASK     11'h7ff

`define QPW_MON_DROPPED      2'h0
`define QPW_MON_GREEN        2'h1
`define QPW_MON_YELLOW       2'h2
`define QPW_MON_RED          2'h3
`define QPW_COLOR_GREEN      2'h1
`define QPW_COLOR_YELLOW     2'h2
`define QPW_COLOR_RED        2'h3

`endif

// ==== hdl/qpw_slot_table.v ====
/*
 Indexed storage for per-port, per-queue rate and burst words, kept in
 flip-flops. Assumes writes arrive as one-cycle strobes in the sys_clk domain.
*/
`timescale 1ns/1ns
`include "qpw_regs.vh"

module qpw_slot_table (
	input  wire        sys_clk,   // Core clock.
	input  wire        reset_n,   // Asynchronous reset, active low.
	input  wire        clk_en,    // State holds while low.
	input  wire [4:0]  wr_slot,   // Slot written.
	input  wire        wr_rate,   // Write strobe for the rate word.
	input  wire        wr_burst,  // Write strobe for the burst word.
	input  wire [31:0] wr_data,   // Write data.
	input  wire [4:0]  rd_slot,   // Slot read.
	output wire [31:0] rd_rate,   // Rate word of the read slot.
	output wire [31:0] rd_burst   // Burst word of the read slot.
);

	reg [31:0] rate_mem  [0:`QPW_NUM_SLOTS-1];
	reg [31:0] burst_mem [0:`QPW_NUM_SLOTS-1];
	integer    i;

	assign rd_rate  = rate_mem[rd_slot];
	assign rd_burst = burst_mem[rd_slot];

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < `QPW_NUM_SLOTS; i = i + 1) begin
				rate_mem[i]  <= `QPW_RATE_RESET;
				burst_mem[i] <= `QPW_BURST_RESET;
			end
		end else if (clk_en) begin
			if (wr_rate)
				rate_mem[wr_slot] <= wr_data;
			if (wr_burst)
				burst_mem[wr_slot] <= wr_data;
		end
	end

endmodule

// ==== test/qpw_bank_sva.sv ====
/*
 Concurrent checks on the ports of the policing register bank.
 Assumes hdl/ on the include path and one sys_clk domain.
*/
`timescale 1ns/1ns
`include "qpw_regs.vh"

module qpw_bank_sva (
	input wire        sys_clk,           // Clock.
	input wire        reset_n,           // Reset, active low.
	input wire        clk_en,            // Clock enable.
	input wire [11:0] reg_addr,          // Offset.
	input wire [31:0] reg_rdata,         // Read data.
	input wire        frame_is_ip,       // IP frame.
	input wire        frame_is_srp,      // SRP frame.
	input wire [1:0]  dscp_color,        // DSCP color.
	input wire [1:0]  remap_color,       // Remapped color.
	input wire        red_drop_request,  // Drop wish.
	input wire        frame_valid,       // Decision cycle.
	input wire        police_active,     // Policing on.
	input wire        color_blind,       // Blind mode.
	input wire [1:0]  input_color,       // Policer color.
	input wire        mark_enable,       // Marking on.
	input wire        frame_drop         // Drop result.
);
	// Control is observed through the read port while its offset is addressed.
	wire ctl = clk_en && (reg_addr == `QPW_OFF_CONTROL);
	wire aw  = ctl && reg_rdata[0] && !reg_rdata[1] && frame_valid;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_enable_follows: assert property (ctl |=> police_active == $past(reg_rdata[0]))
		else $error("enable output does not follow control");
	a_bypass_no_drop: assert property (ctl && !reg_rdata[0] |=> !frame_drop)
		else $error("drop while disabled");
	a_blind_mode: assert property (ctl && reg_rdata[0] |=> color_blind == $past(reg_rdata[1]))
		else $error("mode output wrong");
	a_blind_no_color: assert property (color_blind |-> input_color == 2'h0)
		else $error("color passed in blind mode");
	a_srp_protected: assert property (ctl && reg_rdata[0] && !reg_rdata[2] && frame_valid
		&& frame_is_srp |=> !frame_drop)
		else $error("protected frame dropped");
	a_dscp_color: assert property (aw && frame_is_ip |=> input_color ==
		($past(reg_rdata[3]) ? $past(remap_color) : $past(dscp_color)))
		else $error("IP frame color wrong");
	a_mark_follows: assert property (ctl && reg_rdata[0] |=> mark_enable == $past(reg_rdata[4]))
		else $error("mark output wrong");
	a_nonip_color: assert property (aw && !frame_is_ip |=> input_color == $past(reg_rdata[6:5]))
		else $error("non-IP color wrong");
	a_request_drop: assert property (ctl && reg_rdata[0] && !reg_rdata[10] && frame_valid
		&& !frame_is_srp |=> frame_drop == $past(red_drop_request))
		else $error("drop does not follow request");
	a_reserved_zero: assert property (reg_addr == `QPW_OFF_CONTROL |-> reg_rdata[31:12] == 20'h0)
		else $error("reserved control bits set");

	cover property (frame_drop);
	cover property (color_blind);
	cover property (ctl && reg_rdata[10] && frame_valid);
endmodule

bind qpw_bank qpw_bank_sva u_qpw_bank_sva (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_rdata,
	.frame_is_ip, .frame_is_srp, .dscp_color, .remap_color, .red_drop_request, .frame_valid,
	.police_active, .color_blind, .input_color, .mark_enable, .frame_drop);

// ==== test/qpw_bank_tb.sv ====
/*
 Self-checking bench for the policing register bank.
 Assumes hdl/ on the include path and the checker bound to the bank.
*/
`timescale 1ns/1ns
`include "qpw_regs.vh"

module qpw_bank_tb;
	logic        sys_clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic        frame_is_ip = 0, frame_is_srp = 0, red_drop_request = 0, frame_valid = 0;
	logic [11:0] reg_addr = `QPW_OFF_CONTROL;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [10:0] avg_queue_size = 11'h155, max_threshold, min_threshold, memory_drop_scale;
	logic [23:0] cnt [4] = '{24'h0a0b0c, 24'h111213, 24'h212223, 24'h313233};
	logic [2:0]  frame_port = 3'h0;
	logic [1:0]  frame_queue = 2'h0, dscp_color = 2'h2, remap_color = 2'h1, input_color;
	logic [1:0]  monitor_select;
	logic        police_active, color_blind, mark_enable, drop_all_above_max, frame_drop;
	logic        count_dropped_only;
	logic [15:0] committed_rate, peak_rate, committed_burst, peak_burst;
	int          fail_count = 0, n_checks = 0, p, q;

	always #25 sys_clk = ~sys_clk;

	qpw_bank u_qpw_bank (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .avg_queue_size, .dropped_count(cnt[0]), .green_count(cnt[1]),
		.yellow_count(cnt[2]), .red_count(cnt[3]), .frame_port, .frame_queue, .frame_is_ip,
		.frame_is_srp, .dscp_color, .remap_color, .red_drop_request, .frame_valid, .police_active,
		.color_blind, .input_color, .mark_enable, .committed_rate, .peak_rate, .committed_burst,
		.peak_burst, .max_threshold, .min_threshold, .memory_drop_scale, .drop_all_above_max,
		.frame_drop, .count_dropped_only, .monitor_select);

	// Distinct word per port and queue slot.
	function automatic logic [31:0] rv(input int pp, qq);
		return {8'h5a, 4'(pp), 4'(qq), 8'ha5, 4'(qq), 4'(pp)};
	endfunction

	task automatic chk(input logic [31:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge sys_clk);
		reg_wr = 0;
		reg_addr = `QPW_OFF_CONTROL;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(negedge sys_clk);
		reg_addr = a;
		#1 chk(reg_rdata, exp, "register read");
	endtask

	task automatic ptr(input int pp, qq);
		wr(`QPW_OFF_POINTER, {13'h0, 3'(pp), 14'h0, 2'(qq)});
	endtask

	// Expected nibble is {police_active, frame_drop, input_color}.
	task automatic fx(input logic [31:0] c, input logic ip, srp, req, input logic [3:0] exp);
		wr(`QPW_OFF_CONTROL, c);
		frame_valid = 1;
		frame_is_ip = ip;
		frame_is_srp = srp;
		red_drop_request = req;
		repeat (2) @(negedge sys_clk);
		chk(32'({police_active, frame_drop, input_color}), 32'(exp), "frame decision");
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#(50 * 100000);
		fail_count++;
		$display("[ERR] %0t run exceeded its time limit", $time);
		stop_test();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		reset_n = 1;
		rd(`QPW_OFF_CONTROL, 32'h00000020);
		rd(`QPW_OFF_POINTER, 32'h0);
		rd(`QPW_OFF_RATE, 32'h10002000);
		rd(`QPW_OFF_BURST, 32'h10003000);
		rd(`QPW_OFF_THRESH, 32'h04000080);
		rd(`QPW_OFF_PROB, 32'h00200155);
		$display("Test reset values done");
		wr(`QPW_OFF_CONTROL, 32'hffffffff);
		rd(`QPW_OFF_CONTROL, 32'h00000fff);
		wr(`QPW_OFF_THRESH, 32'hffffffff);
		rd(`QPW_OFF_THRESH, 32'h07ff07ff);
		wr(`QPW_OFF_PROB, 32'hffffffff);
		rd(`QPW_OFF_PROB, 32'h07ff0155);
		wr(`QPW_OFF_POINTER, 32'hfff6fffe);
		rd(`QPW_OFF_POINTER, 32'h00060002);
		wr(12'h810, 32'hffffffff);
		rd(12'h810, 32'h0);
		chk(32'({max_threshold, min_threshold}), 32'h003fffff, "thresholds");
		chk(32'({memory_drop_scale, drop_all_above_max, count_dropped_only, monitor_select}),
			32'h00007fff, "drop settings");
		$display("Test field masks done");
		for (p = 0; p < 7; p++)
			for (q = 0; q < 4; q++) begin
				ptr(p, q);
				wr(`QPW_OFF_RATE, rv(p, q));
			end
		for (p = 0; p < 7; p++)
			for (q = 0; q < 4; q++) begin
				ptr(p, q);
				rd(`QPW_OFF_RATE, rv(p, q));
			end
		ptr(6, 3);
		wr(`QPW_OFF_BURST, 32'h12345678);
		rd(`QPW_OFF_BURST, 32'h12345678);
		ptr(0, 0);
		rd(`QPW_OFF_BURST, 32'h10003000);
		$display("Test indexed slots done");
		frame_port = 3'h5;
		frame_queue = 2'h2;
		fx(32'h00000001, 1, 0, 0, 4'ha);
		chk({committed_rate, peak_rate}, rv(0, 2), "aggregate rate");
		fx(32'h00000081, 1, 0, 0, 4'ha);
		chk({committed_rate, peak_rate}, rv(5, 2), "port rate");
		frame_port = 3'h6;
		frame_queue = 2'h3;
		fx(32'h00000081, 1, 0, 0, 4'ha);
		chk({committed_burst, peak_burst}, 32'h12345678, "port burst");
		fx(32'h00000061, 0, 0, 0, 4'hb);
		fx(32'h00000069, 1, 0, 0, 4'h9);
		fx(32'h00000063, 1, 0, 0, 4'h8);
		fx(32'h00000071, 1, 0, 0, 4'ha);
		chk(32'(mark_enable), 32'h1, "marking");
		wr(`QPW_OFF_THRESH, 32'h00ff0010);
		fx(32'h00000401, 1, 0, 0, 4'he);
		fx(32'h00000001, 1, 0, 0, 4'ha);
		fx(32'h00000001, 1, 0, 1, 4'he);
		fx(32'h00000001, 1, 1, 1, 4'ha);
		fx(32'h00000005, 1, 1, 1, 4'he);
		wr(`QPW_OFF_CONTROL, 32'h0);
		repeat (2) @(negedge sys_clk);
		chk(32'({police_active, frame_drop}), 32'h0, "bypass");
		$display("Test frame decisions done");
		for (p = 0; p < 4; p++) begin
			wr(`QPW_OFF_CONTROL, 32'(p) << 8);
			reg_rd = 1;
			rd(`QPW_OFF_MONITOR, {8'h0, cnt[p]});
			reg_rd = 0;
		end
		rd(`QPW_OFF_MONITOR, 32'h0);
		clk_en = 0;
		wr(`QPW_OFF_CONTROL, 32'h00000001);
		rd(`QPW_OFF_CONTROL, 32'h00000300);
		clk_en = 1;
		$display("Test monitor select done");
		stop_test();
	end
endmodule
